// ===== hdl/mrs_pkg.sv
`default_nettype none
package mrs_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [5:0] IDX_RETRAIN = 6'h08;
    localparam logic [5:0] IDX_RATE_SEQ = 6'h0c;
    localparam logic [5:0] IDX_TRAIN_DET = 6'h0e;
    localparam logic [5:0] IDX_RX_THRESH = 6'h13;
    localparam logic [5:0] IDX_CONFIG = 6'h20;
    localparam logic [5:0] IDX_CONTROL = 6'h21;
    localparam logic [5:0] IDX_STATUS = 6'h22;
    localparam logic [5:0] IDX_RATE_WORD = 6'h23;

    localparam logic [7:0] ADDR_RETRAIN = {IDX_RETRAIN, 2'h0};
    localparam logic [7:0] ADDR_RATE_SEQ = {IDX_RATE_SEQ, 2'h0};
    localparam logic [7:0] ADDR_TRAIN_DET = {IDX_TRAIN_DET, 2'h0};
    localparam logic [7:0] ADDR_RX_THRESH = {IDX_RX_THRESH, 2'h0};
    localparam logic [7:0] ADDR_CONFIG = {IDX_CONFIG, 2'h0};
    localparam logic [7:0] ADDR_CONTROL = {IDX_CONTROL, 2'h0};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'h0};
    localparam logic [7:0] ADDR_RATE_WORD = {IDX_RATE_WORD, 2'h0};

    // Field positions.
    localparam int unsigned POS_RETRAIN = 1;
    localparam int unsigned POS_RATE_SEQ = 0;
    localparam int unsigned POS_TRAIN_DET = 7;
    localparam int unsigned POS_RX_THRESH = 2;
    localparam int unsigned POS_AUTO_RATE = 0;
    localparam int unsigned POS_NEW_CFG = 1;
    localparam int unsigned POS_SPEED = 0;
    localparam int unsigned POS_CTS = 4;
    localparam int unsigned POS_RLSD = 5;
    localparam int unsigned POS_ABORT = 8;

    // Values after reset.
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [1:0] RX_THRESH_RESET = 2'h0;
    localparam logic [3:0] SPEED_RESET = 4'h0;
    localparam logic [7:0] ABORT_RESET = 8'h00;
    localparam logic [15:0] RATE_WORD_RESET = 16'h0000;

    // Codes loaded by the device after a retrain outcome.
    localparam logic [7:0] CONFIGURATION_CODE_CLEARDOWN_V34 = 8'h60;
    localparam logic [7:0] CONFIGURATION_CODE_CLEARDOWN_V32 = 8'h70;
    localparam logic [7:0] CONFIGURATION_CODE_FALLBACK_V22 = 8'h82;
    localparam logic [7:0] ABORT_NO_COMMON = 8'h96;

    // Operating mode reported by the data pump.
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_V34 = 3'h1;
    localparam logic [2:0] MODE_V32BIS = 3'h2;
    localparam logic [2:0] MODE_V32 = 3'h3;
    localparam logic [2:0] MODE_V22BIS = 3'h4;
    localparam logic [2:0] MODE_PCM56 = 3'h5;

    // Energy detector levels in negative dBm, indexed by threshold code.
    localparam logic [23:0] LEVEL_ON_TABLE = {6'd16, 6'd26, 6'd33, 6'd43};
    localparam logic [23:0] LEVEL_OFF_TABLE = {6'd21, 6'd31, 6'd38, 6'd48};

    typedef enum logic [1:0] {
        RT_IDLE,
        RT_START,
        RT_ACTIVE
    } mrs_rt_state_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic retrain_req;
        logic rate_seq;
        logic train_det;
        logic [1:0] rx_thresh;
        logic [5:0] on_level;
        logic [5:0] off_level;
        logic [7:0] config_code;
        logic auto_rate;
        logic new_cfg;
        logic [3:0] speed;
        logic cts;
        logic rlsd;
        logic cleared_down;
        logic [7:0] abort_code;
        logic start;
        logic retraining;
        mrs_rt_state_t state;
    } mrs_state_t;

    typedef struct packed {
        logic [15:0] word;
        logic [15:0] rdata;
    } mrs_mem_t;

    // Modes in which a host retrain request may be honoured.
    function automatic logic retrain_mode_ok(input logic [2:0] mode);
        return (mode == MODE_V34) || (mode == MODE_V32BIS) || (mode == MODE_V32)
            || (mode == MODE_V22BIS) || (mode == MODE_PCM56);
    endfunction

    // Modes of the V.32 family that exchange a rate word.
    function automatic logic v32_family(input logic [2:0] mode);
        return (mode == MODE_V32BIS) || (mode == MODE_V32);
    endfunction

endpackage
`default_nettype wire

// ===== hdl/mrs_rate_word_mem.sv
`default_nettype none
module mrs_rate_word_mem
    import mrs_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Write side.
    input wire logic i_write,
    input wire logic [15:0] i_wdata,
    // Read side.
    output logic [15:0] o_rdata
);

    mrs_mem_t s_q;
    mrs_mem_t s_d;

    // The read data is registered so that the bus sees a clean flop output.
    always_comb begin
        s_d = s_q;
        if (i_write) begin
            s_d.word = i_wdata;
        end
        s_d.rdata = s_q.word;
    end

    // State register.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= '{word: RATE_WORD_RESET, rdata: RATE_WORD_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;

endmodule
`default_nettype wire

// ===== hdl/mrs_retrain_status.sv
`default_nettype none
// Operation
// [RULE1] Set rate flag when V.32 rate word stored.
// [RULE2] Rate flag stays set until host clears.
// [RULE3] Flag incoming training sequence in data modes.
// [RULE4] Flag mirrors answer-tone or S1 detector.
// [RULE5] Threshold code selects detector on/off levels.
// [RULE6] Host retrain request starts retrain in mode.
// [RULE7] Request bit clears when start is acknowledged.
// [RULE8] Host writes config first, request last.
// [RULE9] Host changes rate only, never modulation mode.
// [RULE10] Accepted retrain loads new configuration code.
// [RULE11] Clear-to-send low throughout a retrain.
// [RULE12] Speed bits refreshed when retrain ends.
// [RULE13] No common rate: drop RLSD or abort 96h.
// [RULE14] Cleardown loads config 60h or 70h. A V.22bis cleardown here leaves the config code unchanged.
// [RULE15] V.22 fallback loads config 82h.
// [RULE16] Request outside data modes is dropped.
module mrs_retrain_status
    import mrs_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // APB slave.
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // Data pump status.
    input wire logic [2:0] i_mode,
    input wire logic i_v32_answer,
    input wire logic i_rate_word_valid,
    input wire logic [15:0] i_rate_word,
    input wire logic i_training_seq_det,
    input wire logic i_answer_tone_det,
    input wire logic i_s1_det,
    input wire logic i_energy_detect,
    // Retrain outcome from the data pump.
    input wire logic i_retrain_done,
    input wire logic i_retrain_accepted,
    input wire logic [7:0] i_new_config,
    input wire logic [3:0] i_new_speed,
    input wire logic i_v22_fallback,
    // Data pump control.
    output logic o_retrain_start,
    output logic o_retraining,
    output logic o_cts,
    output logic o_rlsd,
    output logic [1:0] o_rx_threshold,
    output logic [5:0] o_on_level_dbm,
    output logic [5:0] o_off_level_dbm,
    output logic [7:0] o_abort_reason_code
);

    mrs_state_t s_q;
    mrs_state_t s_d;
    logic [15:0] rate_word_rd;
    logic bus_access;
    logic bus_write;
    logic retrain_end;
    logic req_write;

    // The access is taken on the edge where pready is already high.
    assign bus_access = i_psel && i_penable && s_q.pready;
    assign bus_write = bus_access && i_pwrite;
    assign req_write = bus_write && (i_paddr == ADDR_RETRAIN);
    assign retrain_end = (s_q.state == RT_ACTIVE) && i_retrain_done;

    // The captured rate word sits in its own storage and is read back over the bus.
    mrs_rate_word_mem u_rate_word (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_write(i_rate_word_valid && v32_family(i_mode)), // [RULE1]
        .i_wdata(i_rate_word),
        .o_rdata(rate_word_rd)
    );

    // Next-state logic. Host writes are applied first, device events after,
    // so that a device update in the same cycle wins, except that a host write of the retrain request stands.
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;

        // One wait state on every access keeps all bus outputs registered.
        s_d.pready = i_psel && i_penable && !s_q.pready;
        s_d.prdata = 32'h0000_0000;
        s_d.pslverr = 1'b0;
        if (i_psel && i_penable && !s_q.pready && !i_pwrite) begin
            unique case (i_paddr)
                ADDR_RETRAIN: s_d.prdata[POS_RETRAIN] = s_q.retrain_req;
                ADDR_RATE_SEQ: s_d.prdata[POS_RATE_SEQ] = s_q.rate_seq;
                ADDR_TRAIN_DET: s_d.prdata[POS_TRAIN_DET] = s_q.train_det;
                ADDR_RX_THRESH: s_d.prdata[POS_RX_THRESH +: 2] = s_q.rx_thresh;
                ADDR_CONFIG: s_d.prdata[7:0] = s_q.config_code;
                ADDR_CONTROL: begin
                    s_d.prdata[POS_AUTO_RATE] = s_q.auto_rate;
                    s_d.prdata[POS_NEW_CFG] = s_q.new_cfg;
                end
                ADDR_STATUS: begin
                    s_d.prdata[POS_SPEED +: 4] = s_q.speed;
                    s_d.prdata[POS_CTS] = s_q.cts;
                    s_d.prdata[POS_RLSD] = s_q.rlsd;
                    s_d.prdata[POS_ABORT +: 8] = s_q.abort_code;
                end
                ADDR_RATE_WORD: s_d.prdata[15:0] = rate_word_rd;
                default: s_d.pslverr = 1'b1;
            endcase
        end else if (i_psel && i_penable && !s_q.pready) begin
            unique case (i_paddr)
                ADDR_RETRAIN, ADDR_RATE_SEQ, ADDR_TRAIN_DET, ADDR_RX_THRESH,
                ADDR_CONFIG, ADDR_CONTROL, ADDR_STATUS, ADDR_RATE_WORD: begin
                    s_d.pslverr = 1'b0;
                end
                default: s_d.pslverr = 1'b1;
            endcase
        end

        // Register writes; read-only fields ignore the data.
        if (bus_write) begin
            unique case (i_paddr)
                ADDR_RETRAIN: s_d.retrain_req = i_pwdata[POS_RETRAIN];
                ADDR_RATE_SEQ: begin
                    if (!i_pwdata[POS_RATE_SEQ]) begin
                        s_d.rate_seq = 1'b0;
                    end
                end
                ADDR_RX_THRESH: s_d.rx_thresh = i_pwdata[POS_RX_THRESH +: 2];
                ADDR_CONFIG: s_d.config_code = i_pwdata[7:0];
                ADDR_CONTROL: begin
                    s_d.auto_rate = i_pwdata[POS_AUTO_RATE];
                    s_d.new_cfg = i_pwdata[POS_NEW_CFG];
                end
                ADDR_STATUS: s_d.speed = i_pwdata[POS_SPEED +: 4]; // [RULE12]
                default: s_d.pslverr = s_d.pslverr;
            endcase
        end

        // A stored rate word raises the sticky flag, even against a host clear.
        if (i_rate_word_valid && v32_family(i_mode)) begin
            s_d.rate_seq = 1'b1; // [RULE1] [RULE2]
        end

        // Training detector follows the detector that belongs to the mode.
        if (i_mode == MODE_V32 && i_v32_answer) begin
            s_d.train_det = i_answer_tone_det; // [RULE4]
        end else if (i_mode == MODE_V22BIS) begin
            s_d.train_det = i_s1_det; // [RULE4]
        end else if (retrain_mode_ok(i_mode)) begin
            s_d.train_det = i_training_seq_det; // [RULE3]
        end else begin
            s_d.train_det = 1'b0;
        end

        // Energy detector levels for the selected threshold code.
        s_d.on_level = LEVEL_ON_TABLE[6 * s_q.rx_thresh +: 6]; // [RULE5]
        s_d.off_level = LEVEL_OFF_TABLE[6 * s_q.rx_thresh +: 6]; // [RULE5]

        // Retrain sequencer. A request made during a retrain waits until it ends.
        // A host write in the acknowledge cycle stands as a new request.
        unique case (s_q.state)
            RT_IDLE: begin
                if (s_q.retrain_req && retrain_mode_ok(i_mode)) begin
                    s_d.start = 1'b1; // [RULE6]
                    s_d.retrain_req = req_write && i_pwdata[POS_RETRAIN]; // [RULE7]
                    s_d.state = RT_START;
                end else if (s_q.retrain_req) begin
                    s_d.retrain_req = req_write && i_pwdata[POS_RETRAIN]; // [RULE16]
                end
            end
            RT_START: begin
                s_d.state = RT_ACTIVE;
            end
            RT_ACTIVE: begin
                if (i_retrain_done) begin
                    s_d.state = RT_IDLE;
                    s_d.speed = i_new_speed; // [RULE12]
                    if (i_retrain_accepted) begin
                        s_d.config_code = i_new_config; // [RULE10]
                    end else if (i_mode == MODE_V34 || i_mode == MODE_PCM56) begin
                        s_d.abort_code = ABORT_NO_COMMON; // [RULE13]
                        s_d.config_code = CONFIGURATION_CODE_CLEARDOWN_V34; // [RULE14]
                        s_d.cleared_down = 1'b1;
                    end else if (v32_family(i_mode)) begin
                        s_d.config_code = CONFIGURATION_CODE_CLEARDOWN_V32; // [RULE14]
                        s_d.cleared_down = 1'b1; // [RULE13]
                    end else begin
                        s_d.cleared_down = 1'b1;
                    end
                end else if (!retrain_mode_ok(i_mode)) begin
                    s_d.state = RT_IDLE;
                end
            end
        endcase

        // The fallback code is loaded last so that it overrides every other configuration code.
        if (i_v22_fallback) begin
            s_d.config_code = CONFIGURATION_CODE_FALLBACK_V22; // [RULE15]
        end

        // A cleardown holds until the pump leaves the data mode.
        if (i_mode == MODE_IDLE) begin
            s_d.cleared_down = 1'b0;
        end
        s_d.rlsd = i_energy_detect && !s_d.cleared_down; // [RULE13]

        // Kept as a flop so that the status output needs no decode.
        s_d.retraining = (s_d.state != RT_IDLE); // [RULE6]

        // Clear-to-send is withheld while a retrain is starting or running.
        s_d.cts = retrain_mode_ok(i_mode) && (s_d.state == RT_IDLE)
            && !s_d.cleared_down; // [RULE11]
    end

    // State register.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_q <= '{
                pready: 1'b0,
                pslverr: 1'b0,
                prdata: 32'h0000_0000,
                retrain_req: 1'b0,
                rate_seq: 1'b0,
                train_det: 1'b0,
                rx_thresh: RX_THRESH_RESET,
                on_level: LEVEL_ON_TABLE[5:0],
                off_level: LEVEL_OFF_TABLE[5:0],
                config_code: CONFIG_RESET,
                auto_rate: 1'b0,
                new_cfg: 1'b0,
                speed: SPEED_RESET,
                cts: 1'b0,
                rlsd: 1'b0,
                cleared_down: 1'b0,
                abort_code: ABORT_RESET,
                start: 1'b0,
                retraining: 1'b0,
                state: RT_IDLE
            };
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register.
    assign o_pready = s_q.pready;
    assign o_prdata = s_q.prdata;
    assign o_pslverr = s_q.pslverr;
    assign o_retrain_start = s_q.start;
    assign o_retraining = s_q.retraining;
    assign o_cts = s_q.cts;
    assign o_rlsd = s_q.rlsd;
    assign o_rx_threshold = s_q.rx_thresh;
    assign o_on_level_dbm = s_q.on_level;
    assign o_off_level_dbm = s_q.off_level;
    assign o_abort_reason_code = s_q.abort_code;

    // Checks on the sequencer and flags.
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    a_retrain_ack_start: assert property ( // [RULE6]
        (s_q.state == RT_IDLE && s_q.retrain_req && retrain_mode_ok(i_mode))
        |=> (o_retrain_start && o_retraining) ##1 !o_retrain_start)
        else $error("Retrain request did not start a retrain.");

    a_retrain_req_clear: assert property ( // [RULE7]
        (s_q.state == RT_IDLE && s_q.retrain_req && !bus_write)
        |=> !s_q.retrain_req)
        else $error("Retrain request not cleared on acknowledge.");

    a_unsupported_drop: assert property ( // [RULE16]
        (s_q.state == RT_IDLE && s_q.retrain_req && !retrain_mode_ok(i_mode))
        |=> !o_retrain_start && !o_retraining)
        else $error("Retrain started outside a data mode.");

    a_rate_flag_set: assert property ( // [RULE1]
        (i_rate_word_valid && v32_family(i_mode)) |=> s_q.rate_seq
        ##1 (rate_word_rd == $past(i_rate_word, 2)))
        else $error("Rate word flag or storage missing.");

    a_rate_flag_sticky: assert property ( // [RULE2]
        (s_q.rate_seq && !(bus_write && i_paddr == ADDR_RATE_SEQ)) |=> s_q.rate_seq)
        else $error("Rate flag cleared without host write.");

    a_train_mirror_s1: assert property ( // [RULE4]
        (i_mode == MODE_V22BIS) |=> (s_q.train_det == $past(i_s1_det)))
        else $error("Training flag does not follow S1 detector.");

    a_cts_retrain: assert property ( // [RULE11]
        o_retrain_start |-> !o_cts throughout (o_retraining [*2]))
        else $error("Clear-to-send high during a retrain.");

    a_cleardown_v34: assert property ( // [RULE14]
        (retrain_end && !i_retrain_accepted && i_mode == MODE_V34 && !i_v22_fallback)
        |=> (s_q.config_code == CONFIGURATION_CODE_CLEARDOWN_V34) && (o_abort_reason_code == 8'h96))
        else $error("V.34 cleardown codes not loaded.");

    a_cleardown_v32: assert property ( // [RULE13]
        (retrain_end && !i_retrain_accepted && v32_family(i_mode))
        |=> !o_rlsd && !o_cts)
        else $error("RLSD not dropped after V.32 cleardown.");

    a_accept_config: assert property ( // [RULE10]
        (retrain_end && i_retrain_accepted && !i_v22_fallback)
        |=> (s_q.config_code == $past(i_new_config)) && (s_q.speed == $past(i_new_speed)))
        else $error("Accepted retrain did not update configuration.");

    a_fallback_code: assert property ( // [RULE15]
        i_v22_fallback |=> (s_q.config_code == 8'h82))
        else $error("Fallback configuration code not loaded.");

    a_thresh_levels: assert property ( // [RULE5]
        (s_q.rx_thresh == 2'h3) |=> (o_on_level_dbm == 6'd16) && (o_off_level_dbm == 6'd21))
        else $error("Threshold levels wrong for code three.");

    a_rlsd_energy: assert property ( // [RULE13]
        !i_energy_detect
        |=> !o_rlsd)
        else $error("Line signal detect high without energy.");

    a_cts_idle_mode: assert property ( // [RULE11]
        (i_mode == MODE_IDLE)
        |=> !o_cts)
        else $error("Clear-to-send high outside a data mode.");

    a_train_mirror_tone: assert property ( // [RULE4]
        (i_mode == MODE_V32 && i_v32_answer)
        |=> (s_q.train_det == $past(i_answer_tone_det)))
        else $error("Training flag does not follow answer tone detector.");

    c_retrain_start: cover property (o_retrain_start);
    c_retrain_accept: cover property (retrain_end && i_retrain_accepted);
    c_retrain_cleardown: cover property (retrain_end && !i_retrain_accepted);
    c_rate_word: cover property (i_rate_word_valid && v32_family(i_mode));

endmodule
`default_nettype wire

// ===== bench/mrs_pump_model.sv
`default_nettype none
// Data pump and remote modem stand-in: answers each retrain start after a set delay.
module mrs_pump_model (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Retrain handshake.
    input wire logic i_start,
    output logic o_done,
    output logic o_accepted,
    output logic [7:0] o_new_config,
    output logic [3:0] o_new_speed,
    // Outcome chosen by the bench.
    input wire logic i_accept,
    input wire logic [7:0] i_cfg,
    input wire logic [3:0] i_spd,
    input wire logic [7:0] i_delay,
    output logic [7:0] o_starts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_q;
    logic busy_q;
    // Outcome lines toggle outside the done pulse, so a stale value never passes for data.
    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            {o_done, o_accepted, o_new_config, o_new_speed, busy_q, cnt_q, o_starts} <= '0;
        end else begin
            o_done <= 1'b0;
            o_accepted <= ~o_accepted;
            o_new_config <= ~o_new_config;
            o_new_speed <= ~o_new_speed;
            if (i_start) begin
                busy_q <= 1'b1;
                cnt_q <= i_delay;
                o_starts <= o_starts + 8'h01;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    busy_q <= 1'b0;
                    o_done <= 1'b1;
                    o_accepted <= i_accept;
                    o_new_config <= i_cfg;
                    o_new_speed <= i_spd;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/tb.sv
`default_nettype none
module tb
    import mrs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_rst_n, i_psel, i_penable, i_pwrite, i_v32_answer, i_rate_word_valid;
    logic i_training_seq_det, i_answer_tone_det, i_s1_det, i_energy_detect, i_retrain_done;
    logic i_retrain_accepted, i_v22_fallback, o_pready, o_pslverr, o_retrain_start;
    logic o_retraining, o_cts, o_rlsd, acc_k, err_v;
    logic [1:0] o_rx_threshold;
    logic [2:0] i_mode;
    logic [3:0] i_new_speed, spd_k;
    logic [5:0] o_on_level_dbm, o_off_level_dbm;
    logic [7:0] i_paddr, i_new_config, o_abort_reason_code, cfg_k, dly_k, starts;
    logic [15:0] i_rate_word;
    logic [31:0] i_pwdata, o_prdata, rd_v;
    int bad_count, samples_checked;

    mrs_retrain_status i_dut (.i_clock, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_mode, .i_v32_answer,
        .i_rate_word_valid, .i_rate_word, .i_training_seq_det, .i_answer_tone_det, .i_s1_det,
        .i_energy_detect, .i_retrain_done, .i_retrain_accepted, .i_new_config, .i_new_speed,
        .i_v22_fallback, .o_retrain_start, .o_retraining, .o_cts, .o_rlsd, .o_rx_threshold,
        .o_on_level_dbm, .o_off_level_dbm, .o_abort_reason_code);
    mrs_pump_model i_pump (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_start(o_retrain_start),
        .o_done(i_retrain_done), .o_accepted(i_retrain_accepted), .o_new_config(i_new_config),
        .o_new_speed(i_new_speed), .i_accept(acc_k), .i_cfg(cfg_k), .i_spd(spd_k),
        .i_delay(dly_k), .o_starts(starts));

    // Free-running 100 MHz clock.
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the answer is taken at the edge that samples pready high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clock);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
        @(posedge i_clock);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        {rd_v, err_v} = {o_prdata, o_pslverr};
        chk({31'h0, o_pready}, 32'h1);
        {i_psel, i_penable} <= 2'b00;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        apb(1'b0, a, 32'h0);
        chk(rd_v & m, e);
    endtask

    // Bounded wait for the retraining flag to reach a level.
    task automatic wait_rt(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_retraining !== lvl && n < 100);
        chk({31'h0, o_retraining}, {31'h0, lvl});
    endtask

    // A long delay leaves room for host accesses while the retrain runs.
    task automatic run_retrain(input logic acc, input logic [7:0] cfg, input logic [7:0] dly);
        logic [7:0] s0;
        s0 = starts;
        {acc_k, cfg_k, spd_k, dly_k} <= {acc, cfg, 4'h9, dly};
        apb(1'b1, ADDR_RETRAIN, 32'h2);
        wait_rt(1'b1);
        chk({31'h0, o_cts}, 32'h0);
        if (dly > 8'd20) begin
            rd(ADDR_RETRAIN, 32'h0);
            apb(1'b1, ADDR_STATUS, 32'h0);
        end
        wait_rt(1'b0);
        chk({24'h0, starts}, {24'h0, s0 + 8'h01});
    endtask

    task automatic t_reset_and_thresh;
        logic [5:0] on_t [4] = '{6'h2b, 6'h21, 6'h1a, 6'h10};
        logic [5:0] off_t [4] = '{6'h30, 6'h26, 6'h1f, 6'h15};
        rd(ADDR_RETRAIN, 32'h0);
        rd(ADDR_CONFIG, 32'h0);
        rd(8'hfc, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_RX_THRESH, 32'(i) << 2);
            rd(ADDR_RX_THRESH, 32'(i) << 2);
            chk({30'h0, o_rx_threshold}, 32'(i));
            chk({o_on_level_dbm, o_off_level_dbm}, {20'h0, on_t[i], off_t[i]});
        end
        $display("reset and threshold test done");
    endtask

    // A rate word outside the V.32 family must not raise the flag.
    task automatic t_rate_seq;
        for (int i = 0; i < 2; i++) begin
            i_mode <= (i == 0) ? MODE_PCM56 : MODE_V32;
            @(posedge i_clock);
            {i_rate_word_valid, i_rate_word} <= {1'b1, 16'ha5c3};
            @(posedge i_clock);
            i_rate_word_valid <= 1'b0;
            rd(ADDR_RATE_SEQ, 32'(i));
        end
        rd(ADDR_RATE_WORD, 32'h0000a5c3);
        apb(1'b1, ADDR_RATE_SEQ, 32'h1);
        rd(ADDR_RATE_SEQ, 32'h1);
        apb(1'b1, ADDR_RATE_SEQ, 32'h0);
        rd(ADDR_RATE_SEQ, 32'h0);
        $display("rate sequence test done");
    endtask

    // Each row: mode, answer side, tone, s1, general detector, expected flag.
    task automatic t_train;
        logic [7:0] tab [5] = '{{MODE_V32, 5'b11001}, {MODE_V32, 5'b10010},
            {MODE_V22BIS, 5'b00101}, {MODE_V34, 5'b00011}, {MODE_IDLE, 5'b11110}};
        for (int i = 0; i < 5; i++) begin
            {i_mode, i_v32_answer, i_answer_tone_det, i_s1_det, i_training_seq_det} <= tab[i][7:1];
            rd(ADDR_TRAIN_DET, {24'h0, tab[i][0], 7'h0});
        end
        {i_v32_answer, i_answer_tone_det, i_s1_det, i_training_seq_det} <= 4'h0;
        i_energy_detect <= 1'b0;
        rd(ADDR_STATUS, 32'h0, 32'h20);
        i_energy_detect <= 1'b1;
        $display("training detect test done");
    endtask

    task automatic t_retrain;
        i_mode <= MODE_V34;
        apb(1'b1, ADDR_CONTROL, 32'h0);
        apb(1'b1, ADDR_CONFIG, 32'h000000c4);
        run_retrain(1'b1, 8'hc6, 8'd40);
        rd(ADDR_CONFIG, 32'hc6);
        rd(ADDR_STATUS, 32'h39, 32'h3f);
        chk({30'h0, o_rlsd, o_cts}, 32'h3);
        run_retrain(1'b0, 8'h00, 8'd3);
        rd(ADDR_CONFIG, 32'h60);
        rd(ADDR_STATUS, 32'h9600, 32'hff00);
        chk({24'h0, o_abort_reason_code}, 32'h96);
        i_mode <= MODE_IDLE;
        repeat (3) @(posedge i_clock);
        i_mode <= MODE_V32BIS;
        run_retrain(1'b0, 8'h00, 8'd3);
        rd(ADDR_CONFIG, 32'h70);
        chk({31'h0, o_rlsd}, 32'h0);
        i_mode <= MODE_V22BIS;
        @(posedge i_clock);
        i_v22_fallback <= 1'b1;
        @(posedge i_clock);
        i_v22_fallback <= 1'b0;
        rd(ADDR_CONFIG, 32'h82);
        $display("retrain test done");
    endtask

    task automatic t_ignore;
        logic [7:0] s0;
        s0 = starts;
        i_mode <= MODE_IDLE;
        apb(1'b1, ADDR_RETRAIN, 32'h2);
        rd(ADDR_RETRAIN, 32'h0);
        chk({24'h0, starts}, {24'h0, s0});
        $display("ignored request test done");
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence; every input has a value at time zero.
    initial begin
        {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_mode, i_v32_answer} = '0;
        {i_rate_word_valid, i_rate_word, i_training_seq_det, i_answer_tone_det} = '0;
        {i_s1_det, i_v22_fallback, acc_k, cfg_k, spd_k, dly_k} = '0;
        i_energy_detect = 1'b1;
        {bad_count, samples_checked} = '0;
        repeat (16) @(posedge i_clock);
        i_rst_n <= 1'b1;
        t_reset_and_thresh();
        t_rate_seq();
        t_train();
        t_retrain();
        t_ignore();
        complete_run();
    end

    // The tests need well under a thousand cycles, so a hang is cut at five thousand.
    initial begin
        #50000;
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
